/* File: pkg/gw_acq_pkg.sv */
// Contract
// - Keep scanning until tunnel channel found
// - No scan before advanced mode set
// - No control descriptor found: tune next channel
// - No matching domain descriptor: legacy init
// - Resolve service group before forwarding descriptors
// - Valid channel: continue initialization and registration
// - Invalid: scan group, drop foreign descriptors
// - All rejected: resume general downstream scan
// - Upstream, IP or registration failure: one-way
// - Presence timer expiry continues downstream scan
// - Descriptor found stops timer, signals found
// - Use only domain fragments matching source MAC
// - Two parallel machines; tunnel feeds init
// - Found and continue-scan stay internal
// - Disable upstream stops every transmit channel
// - Two-way OK reports channel id 255
// - Provide the five controller notifications
// - Tunnel machine takes three commands, returns two
// - Tunnels told apart and filtered by MAC
// - Upstream disabled: keep downstream, two-way disabled
package gw_acq_pkg;

  localparam int MAC_W = 48;
  localparam int FREQ_W = 32;
  localparam int N_TUNNEL = 4;
  localparam int N_US = 4;
  localparam logic [7:0] UPSTREAM_CHANNEL_ID_RSVD = 8'hFF;
  localparam int unsigned PRESENCE_TIME_MS = 2000;
  localparam int unsigned CLK_MHZ = 250;

  typedef enum logic [2:0] {
    NOTE_NONE,
    NOTE_SCAN_DONE,
    NOTE_TWO_WAY_OK,
    NOTE_ONE_WAY,
    NOTE_CANNOT_FWD,
    NOTE_CHAN_CHANGE
  } note_kind_e;

  typedef struct packed {
    note_kind_e  kind;
    logic [7:0]  upstream_channel_id;
    logic        network_access_flag;
    logic [7:0]  max_attached_hosts;
    logic [7:0]  init_type;
  } note_s;

  typedef struct packed {
    logic        start_adv;
    logic        filter_wr;
    logic [1:0]  filter_idx;
    logic [MAC_W-1:0] filter_mac;
    logic        filter_en;
    logic        hunt_new;
    logic        chan_valid;
    logic        freq_hint_vld;
    logic [FREQ_W-1:0] freq_hint;
    logic        us_disable;
    logic        us_enable;
  } ctl_cmd_s;

  typedef struct packed {
    logic        locked;
    logic        lock_fail;
    logic        dcd_frag;
    logic [MAC_W-1:0] dcd_src;
    logic        mdd_frag;
    logic [MAC_W-1:0] mdd_src;
    logic        mdd_none;
    logic        sg_done;
    logic        group_end;
    logic        us_fail;
    logic        ip_fail;
    logic        reg_fail;
    logic        reg_ok;
    logic        chan_change;
    logic [7:0]  chan_change_type;
    logic        cannot_fwd;
    logic        cannot_fwd_naf;
    logic [7:0]  cannot_fwd_hosts;
    logic        tun_vld;
    logic [MAC_W-1:0] tun_dst;
  } phy_evt_s;

endpackage

/* File: rtl/gw_acq.sv */
`timescale 1ns/1ps
`default_nettype none
module gw_acq
  import gw_acq_pkg::*;
#(
  parameter int unsigned PRESENCE_CYCLES = PRESENCE_TIME_MS * 1000 * CLK_MHZ
) (
  // Clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  // Controller commands and notices
  input  wire gw_acq_pkg::ctl_cmd_s    cmd,
  output var  gw_acq_pkg::note_s       note_ff,
  output logic                         note_vld_ff,
  output logic                         dcd_fwd_ff,
  output logic [gw_acq_pkg::MAC_W-1:0] dcd_fwd_src_ff,
  output logic                         mac_reinit_ff,
  // Tuner and MAC engine
  input  wire gw_acq_pkg::phy_evt_s    evt,
  output logic                         tune_next_ff,
  output logic                         tune_group_ff,
  output logic                         tune_hint_ff,
  output logic [gw_acq_pkg::FREQ_W-1:0] tune_freq_ff,
  output logic                         legacy_init_ff,
  output logic                         us_start_ff,
  output logic [gw_acq_pkg::N_US-1:0]  us_tx_en_ff,
  output logic                         two_way_dis_ff,
  output logic                         tun_pass_ff
);

  import gw_acq_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_SCAN, S_PRESENCE, S_READ_MDD, S_RESOLVE, S_VALIDATE,
    S_GROUP_SCAN, S_GROUP_PRES, S_US_INIT, S_TWO_WAY, S_ONE_WAY
  } init_e;

  init_e init_ff;
  init_e nxt_init;
  logic [31:0] pres_cnt_ff;
  logic        pres_run_ff;
  logic        chan_found_ff;
  logic        cont_scan_ff;
  logic        adv_mode_ff;
  logic        hold_valid_ff;
  logic        hold_invalid_ff;
  logic [MAC_W-1:0] dom_mac_ff;
  logic        dom_known_ff;
  logic        us_off_ff;
  logic [MAC_W-1:0] filt_mac_ff [N_TUNNEL];
  logic [N_TUNNEL-1:0] filt_en_ff;
  logic [N_TUNNEL-1:0] tun_hit;

  function automatic logic mac_match(input logic [MAC_W-1:0] a, input logic [MAC_W-1:0] b);
    mac_match = (a == b);
  endfunction

  // Tunnel machine: advanced mode latch and channel verdicts
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      adv_mode_ff <= 1'b0;
    end else if (cmd.start_adv) begin
      adv_mode_ff <= 1'b1;
    end
  end

  // Verdicts are internal inputs to the init machine; never routed out
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      hold_valid_ff   <= 1'b0;
      hold_invalid_ff <= 1'b0;
    end else begin
      hold_valid_ff   <= cmd.chan_valid;
      hold_invalid_ff <= cmd.hunt_new;
    end
  end

  // Presence timer on the system clock
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pres_cnt_ff   <= 32'h0;
      pres_run_ff   <= 1'b0;
      chan_found_ff <= 1'b0;
      cont_scan_ff  <= 1'b0;
    end else begin
      chan_found_ff <= 1'b0;
      cont_scan_ff  <= 1'b0;
      if ((init_ff == S_PRESENCE || init_ff == S_GROUP_PRES) && !pres_run_ff
          && !chan_found_ff && !cont_scan_ff) begin
        pres_run_ff <= 1'b1;
        pres_cnt_ff <= 32'h0;
      end else if (pres_run_ff) begin
        if (evt.dcd_frag) begin
          pres_run_ff <= 1'b0;
          // A foreign descriptor in the group is dropped; waiting for a verdict
          // on it would stall, since the controller never sees it
          if (init_ff == S_GROUP_PRES && !mac_match(evt.dcd_src, dom_mac_ff)) begin
            cont_scan_ff <= 1'b1;
          end else begin
            chan_found_ff <= 1'b1;
          end
        end else if (pres_cnt_ff >= PRESENCE_CYCLES - 1) begin
          pres_run_ff  <= 1'b0;
          cont_scan_ff <= 1'b1;
        end else begin
          pres_cnt_ff <= pres_cnt_ff + 32'h1;
        end
      end
    end
  end

  // Domain address captured from the first descriptor seen on the channel
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dom_mac_ff   <= '0;
      dom_known_ff <= 1'b0;
    end else if (init_ff == S_SCAN) begin
      dom_known_ff <= 1'b0;
    end else if (init_ff == S_PRESENCE && evt.dcd_frag && !dom_known_ff) begin
      dom_mac_ff   <= evt.dcd_src;
      dom_known_ff <= 1'b1;
    end
  end

  // Initialization machine
  always_comb begin
    nxt_init = init_ff;
    case (init_ff)
      S_IDLE:       if (adv_mode_ff) nxt_init = S_SCAN;
      S_SCAN:       if (evt.locked) nxt_init = S_PRESENCE;
      S_PRESENCE: begin
        if (chan_found_ff) nxt_init = S_READ_MDD;
        else if (cont_scan_ff) nxt_init = S_SCAN;
      end
      S_READ_MDD: begin
        if (evt.mdd_frag && mac_match(evt.mdd_src, dom_mac_ff)) nxt_init = S_RESOLVE;
        else if (evt.mdd_none) nxt_init = S_US_INIT;
      end
      S_RESOLVE:    if (evt.sg_done) nxt_init = S_VALIDATE;
      S_VALIDATE: begin
        if (hold_valid_ff) nxt_init = S_US_INIT;
        else if (hold_invalid_ff) nxt_init = S_GROUP_SCAN;
      end
      S_GROUP_SCAN: begin
        if (evt.group_end) nxt_init = S_SCAN;
        else if (evt.locked) nxt_init = S_GROUP_PRES;
      end
      S_GROUP_PRES: begin
        if (chan_found_ff) nxt_init = S_VALIDATE;
        else if (cont_scan_ff) nxt_init = S_GROUP_SCAN;
      end
      S_US_INIT: begin
        if (evt.us_fail || evt.ip_fail || evt.reg_fail) nxt_init = S_ONE_WAY;
        else if (evt.reg_ok) nxt_init = S_TWO_WAY;
      end
      S_TWO_WAY, S_ONE_WAY: nxt_init = init_ff;
      default:      nxt_init = S_IDLE;
    endcase
    if (evt.lock_fail && init_ff inside {S_PRESENCE, S_READ_MDD, S_RESOLVE}) begin
      nxt_init = S_SCAN;
    end
    if (us_off_ff && init_ff == S_US_INIT) begin
      nxt_init = S_ONE_WAY;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) init_ff <= S_IDLE;
    else         init_ff <= nxt_init;
  end

  // Tuner strobes
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tune_next_ff   <= 1'b0;
      tune_group_ff  <= 1'b0;
      tune_hint_ff   <= 1'b0;
      tune_freq_ff   <= '0;
      legacy_init_ff <= 1'b0;
      us_start_ff    <= 1'b0;
    end else begin
      tune_next_ff   <= (nxt_init == S_SCAN) && (init_ff != S_SCAN) && adv_mode_ff;
      tune_group_ff  <= (nxt_init == S_GROUP_SCAN) && (init_ff != S_GROUP_SCAN);
      tune_hint_ff   <= cmd.freq_hint_vld && init_ff == S_SCAN;
      if (cmd.freq_hint_vld) tune_freq_ff <= cmd.freq_hint;
      legacy_init_ff <= (init_ff == S_READ_MDD) && (nxt_init == S_US_INIT);
      us_start_ff    <= (init_ff != S_US_INIT) && (nxt_init == S_US_INIT) && !us_off_ff;
    end
  end

  // Descriptor forwarding only after group resolution
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dcd_fwd_ff     <= 1'b0;
      dcd_fwd_src_ff <= '0;
    end else begin
      dcd_fwd_ff <= 1'b0;
      if (init_ff == S_RESOLVE && evt.sg_done) begin
        dcd_fwd_ff     <= 1'b1;
        dcd_fwd_src_ff <= dom_mac_ff;
      end else if (init_ff == S_GROUP_PRES && evt.dcd_frag
                   && mac_match(evt.dcd_src, dom_mac_ff)) begin
        dcd_fwd_ff     <= 1'b1;
        dcd_fwd_src_ff <= evt.dcd_src;
      end
    end
  end

  // Upstream transmitters; disable wins at any point
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      us_off_ff      <= 1'b0;
      us_tx_en_ff    <= '0;
      two_way_dis_ff <= 1'b0;
    end else begin
      if (cmd.us_disable) begin
        us_off_ff      <= 1'b1;
        us_tx_en_ff    <= '0;
        two_way_dis_ff <= 1'b1;
      end else begin
        if (cmd.us_enable) begin
          us_off_ff      <= 1'b0;
          two_way_dis_ff <= 1'b0;
        end
        if (!us_off_ff && nxt_init == S_TWO_WAY) us_tx_en_ff <= '1;
        else if (nxt_init == S_ONE_WAY) us_tx_en_ff <= '0;
      end
    end
  end

  // Tunnel filter table
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      filt_en_ff <= '0;
      for (int i = 0; i < N_TUNNEL; i++) filt_mac_ff[i] <= '0;
    end else if (cmd.filter_wr) begin
      filt_mac_ff[cmd.filter_idx] <= cmd.filter_mac;
      filt_en_ff[cmd.filter_idx]  <= cmd.filter_en;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_TUNNEL; g++) begin : g_hit
      assign tun_hit[g] = filt_en_ff[g] && mac_match(evt.tun_dst, filt_mac_ff[g]);
    end
  endgenerate

  // Tunnel traffic keeps flowing in one-way and two-way-disabled
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) tun_pass_ff <= 1'b0;
    else         tun_pass_ff <= evt.tun_vld && (|tun_hit) && adv_mode_ff;
  end

  // Controller notifications
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      note_ff       <= '0;
      note_vld_ff   <= 1'b0;
      mac_reinit_ff <= 1'b0;
    end else begin
      note_vld_ff   <= 1'b0;
      mac_reinit_ff <= 1'b0;
      note_ff       <= '0;
      if (init_ff == S_US_INIT && nxt_init == S_TWO_WAY) begin
        note_vld_ff                  <= 1'b1;
        note_ff.kind                 <= NOTE_TWO_WAY_OK;
        note_ff.upstream_channel_id  <= UPSTREAM_CHANNEL_ID_RSVD;
      end else if (init_ff != S_ONE_WAY && nxt_init == S_ONE_WAY) begin
        note_vld_ff  <= 1'b1;
        note_ff.kind <= NOTE_ONE_WAY;
      end else if ((init_ff == S_READ_MDD || init_ff == S_VALIDATE) && nxt_init == S_US_INIT) begin
        note_vld_ff  <= 1'b1;
        note_ff.kind <= NOTE_SCAN_DONE;
      end else if (evt.cannot_fwd) begin
        note_vld_ff                  <= 1'b1;
        note_ff.kind                 <= NOTE_CANNOT_FWD;
        note_ff.network_access_flag  <= evt.cannot_fwd_naf;
        note_ff.max_attached_hosts   <= evt.cannot_fwd_hosts;
      end else if (evt.chan_change) begin
        note_vld_ff       <= 1'b1;
        note_ff.kind      <= NOTE_CHAN_CHANGE;
        note_ff.init_type <= evt.chan_change_type;
      end
      if (init_ff == S_GROUP_SCAN && evt.group_end) begin
        mac_reinit_ff <= 1'b1;
      end
    end
  end

endmodule // gw_acq
`default_nettype wire

/* File: testbench/gw_acq_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module gw_acq_monitor
  import gw_acq_pkg::*;
(
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    sys_rst,
  // Controller side
  input wire gw_acq_pkg::ctl_cmd_s    cmd,
  input wire gw_acq_pkg::note_s       note_ff,
  input wire logic                    note_vld_ff,
  input wire logic                    dcd_fwd_ff,
  // Tuner side
  input wire gw_acq_pkg::phy_evt_s    evt,
  input wire logic                    tune_next_ff,
  input wire logic [gw_acq_pkg::N_US-1:0] us_tx_en_ff
);
  logic adv_ff;
  logic sg_seen_ff;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) adv_ff <= 1'b0;
    else if (cmd.start_adv) adv_ff <= 1'b1;
  end

  // Sticky: any forward must come after some resolution finished
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) sg_seen_ff <= 1'b0;
    else if (evt.sg_done) sg_seen_ff <= 1'b1;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_scan_go;
    ##2 tune_next_ff;
  endsequence

  property p_idle_quiet; !adv_ff |-> !tune_next_ff; endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("scan started before advanced mode");
  property p_start_scan; cmd.start_adv && !adv_ff |-> s_scan_go; endproperty
  a_start_scan: assert property (p_start_scan)
    else $error("no scan two cycles after advanced mode");
  property p_fwd_order; dcd_fwd_ff |-> sg_seen_ff; endproperty
  a_fwd_order: assert property (p_fwd_order)
    else $error("descriptor forwarded before group resolved");
  property p_two_way_id;
    note_vld_ff && note_ff.kind == NOTE_TWO_WAY_OK |-> note_ff.upstream_channel_id == 8'hFF;
  endproperty
  a_two_way_id: assert property (p_two_way_id)
    else $error("two-way note with wrong channel id");
  property p_us_off; cmd.us_disable |-> ##[1:2] us_tx_en_ff == '0; endproperty
  a_us_off: assert property (p_us_off)
    else $error("transmitters still on after disable");
  property p_note_zero; !note_vld_ff |-> note_ff == '0; endproperty
  a_note_zero: assert property (p_note_zero)
    else $error("note fields set without valid");
  property p_tune_pulse; tune_next_ff |=> !tune_next_ff; endproperty
  a_tune_pulse: assert property (p_tune_pulse)
    else $error("tune request longer than one cycle");
  property p_rst_quiet;
    $fell(sys_rst) |-> !tune_next_ff && !dcd_fwd_ff && !note_vld_ff && us_tx_en_ff == '0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active on first edge after reset");
endmodule // gw_acq_monitor

bind gw_acq gw_acq_monitor gw_acq_monitor_inst (.clk_sys, .sys_rst, .cmd, .note_ff,
  .note_vld_ff, .dcd_fwd_ff, .evt, .tune_next_ff, .us_tx_en_ff);
`default_nettype wire

/* File: testbench/ctl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ctl_model
  import gw_acq_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // Bench requests
  input  wire logic                 adv_req,
  input  wire logic                 accept,
  input  wire logic                 off_req,
  input  wire logic                 filt_req,
  input  wire logic                 hint_req,
  input  wire logic [gw_acq_pkg::MAC_W-1:0]  filt_mac,
  input  wire logic [gw_acq_pkg::FREQ_W-1:0] hint_freq,
  // Modem side
  input  wire logic                 dcd_fwd_ff,
  output var  gw_acq_pkg::ctl_cmd_s cmd
);
  logic adv_seen_ff;
  logic off_seen_ff;
  logic filt_seen_ff;
  logic hint_seen_ff;

  // Driven on the falling edge so the modem samples settled commands
  always_ff @(negedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cmd         <= '0;
      adv_seen_ff <= 1'b0;
      off_seen_ff <= 1'b0;
      filt_seen_ff <= 1'b0;
      hint_seen_ff <= 1'b0;
    end else begin
      cmd            <= '0;
      cmd.start_adv  <= adv_req && !adv_seen_ff;
      cmd.chan_valid <= dcd_fwd_ff && accept;
      cmd.hunt_new   <= dcd_fwd_ff && !accept;
      cmd.us_disable <= off_req && !off_seen_ff;
      adv_seen_ff    <= adv_req;
      off_seen_ff    <= off_req;
      cmd.filter_wr     <= filt_req && !filt_seen_ff;
      cmd.filter_mac    <= filt_mac;
      cmd.filter_en     <= 1'b1;
      cmd.freq_hint_vld <= hint_req && !hint_seen_ff;
      cmd.freq_hint     <= hint_freq;
      filt_seen_ff      <= filt_req;
      hint_seen_ff      <= hint_req;
    end
  end
endmodule // ctl_model
`default_nettype wire

/* File: testbench/gw_acq_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module gw_acq_tb;
  import gw_acq_pkg::*;
  typedef enum int {LOCK, DCD, MDD, NOMDD, SGD, GEND, USF, TUN, CANF, CHG, REGOK} ev_e;
  localparam logic [31:0]    HINT_F = 32'h0123_4567;
  localparam int unsigned    PRES  = 20;
  localparam logic [47:0]    MAC_A = 48'h0000_1111_2222;
  localparam logic [47:0]    MAC_B = 48'h0000_3333_4444;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic              adv_req = 1'b0;
  logic              accept  = 1'b1;
  logic              off_req = 1'b0;
  logic              filt_req = 1'b0;
  logic              hint_req = 1'b0;
  ctl_cmd_s          cmd;
  phy_evt_s          evt     = '0;
  note_s             note_ff;
  logic              note_vld_ff, dcd_fwd_ff, mac_reinit_ff, tune_next_ff, tune_group_ff;
  logic              tune_hint_ff, legacy_init_ff, us_start_ff, two_way_dis_ff, tun_pass_ff;
  logic [MAC_W-1:0]  dcd_fwd_src_ff;
  logic [FREQ_W-1:0] tune_freq_ff;
  logic [N_US-1:0]   us_tx_en_ff;
  int                fail_count = 0;
  int                checks     = 0;

  always #2 clk_sys = ~clk_sys;

  gw_acq #(.PRESENCE_CYCLES(PRES)) gw_acq_inst (.clk_sys, .sys_rst, .cmd, .note_ff,
    .note_vld_ff, .dcd_fwd_ff, .dcd_fwd_src_ff, .mac_reinit_ff, .evt, .tune_next_ff,
    .tune_group_ff, .tune_hint_ff, .tune_freq_ff, .legacy_init_ff, .us_start_ff,
    .us_tx_en_ff, .two_way_dis_ff, .tun_pass_ff);
  ctl_model ctl_model_inst (.clk_sys, .sys_rst, .adv_req, .accept, .off_req, .filt_req,
    .hint_req, .filt_mac(MAC_A), .hint_freq(HINT_F), .dcd_fwd_ff, .cmd);

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded look for a pulse; a missed expected pulse ends the run
  task automatic wt(ref logic s, input int n, input logic exp);
    logic hit;
    hit = s;
    for (int i = 0; i < n && !hit; i++) begin
      @(posedge clk_sys);
      #1 hit = s;
    end
    cmp(hit, exp);
    if (exp && !hit) give_verdict();
  endtask

  task automatic ev(input ev_e k, input logic [MAC_W-1:0] src);
    phy_evt_s e;
    e = '0;
    e.dcd_src = src;
    e.mdd_src = src;
    case (k)
      LOCK: e.locked = 1'b1;
      DCD: e.dcd_frag = 1'b1;
      MDD: e.mdd_frag = 1'b1;
      NOMDD: e.mdd_none = 1'b1;
      SGD: e.sg_done = 1'b1;
      GEND: e.group_end = 1'b1;
      USF: e.us_fail = 1'b1;
      TUN: begin
        e.tun_vld = 1'b1;
        e.tun_dst = src;
      end
      CANF: begin
        e.cannot_fwd = 1'b1;
        e.cannot_fwd_naf = src[0];
        e.cannot_fwd_hosts = src[7:0];
      end
      CHG: begin
        e.chan_change = 1'b1;
        e.chan_change_type = src[7:0];
      end
      default: e.reg_ok = 1'b1;
    endcase
    @(negedge clk_sys);
    evt <= e;
    @(negedge clk_sys);
    evt <= '0;
  endtask

  task automatic do_reset();
    @(negedge clk_sys);
    sys_rst <= 1'b1;
    adv_req <= 1'b0;
    off_req <= 1'b0;
    repeat (8) @(negedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic t_idle();
    hint_req <= 1'b1;
    wt(tune_hint_ff, 4, 1'b0);
    hint_req <= 1'b0;
    ev(LOCK, '0);
    wt(tune_next_ff, 10, 1'b0);
    adv_req <= 1'b1;
    wt(tune_next_ff, 6, 1'b1);
    hint_req <= 1'b1;
    wt(tune_hint_ff, 4, 1'b1);
    cmp(tune_freq_ff, HINT_F);
  endtask

  task automatic t_timeout();
    ev(LOCK, '0);
    wt(tune_next_ff, PRES - 4, 1'b0);
    wt(tune_next_ff, 12, 1'b1);
  endtask

  // Reaches the resolved primary channel, partner answers per accept
  task automatic to_fwd();
    ev(LOCK, '0);
    ev(DCD, MAC_A);
    wt(dcd_fwd_ff, 3, 1'b0);
    ev(MDD, MAC_B);
    wt(dcd_fwd_ff, 3, 1'b0);
    ev(MDD, MAC_A);
    ev(SGD, '0);
    wt(dcd_fwd_ff, 4, 1'b1);
    cmp(dcd_fwd_src_ff, MAC_A);
  endtask

  task automatic t_accept();
    filt_req <= 1'b1;
    to_fwd();
    wt(us_start_ff, 6, 1'b1);
    wt(note_vld_ff, 2, 1'b1);
    cmp(note_ff.kind, NOTE_SCAN_DONE);
    ev(REGOK, '0);
    wt(note_vld_ff, 4, 1'b1);
    cmp(note_ff.kind, NOTE_TWO_WAY_OK);
    cmp(note_ff.upstream_channel_id, 8'hFF);
    @(negedge clk_sys);
    cmp(us_tx_en_ff, 4'hF);
    off_req <= 1'b1;
    wt(two_way_dis_ff, 6, 1'b1);
    cmp(us_tx_en_ff, 4'h0);
    ev(TUN, MAC_A);
    wt(tun_pass_ff, 4, 1'b1);
    ev(TUN, MAC_B);
    wt(tun_pass_ff, 4, 1'b0);
  endtask

  task automatic t_hunt();
    do_reset();
    accept <= 1'b0;
    adv_req <= 1'b1;
    wt(tune_next_ff, 6, 1'b1);
    to_fwd();
    wt(tune_group_ff, 6, 1'b1);
    ev(LOCK, '0);
    ev(DCD, MAC_B);
    wt(dcd_fwd_ff, 4, 1'b0);
    ev(LOCK, '0);
    ev(DCD, MAC_A);
    wt(dcd_fwd_ff, 4, 1'b1);
    cmp(dcd_fwd_src_ff, MAC_A);
    wt(tune_group_ff, 6, 1'b1);
    ev(GEND, '0);
    wt(mac_reinit_ff, 4, 1'b1);
    wt(tune_next_ff, 4, 1'b1);
  endtask

  task automatic t_legacy();
    ev(LOCK, '0);
    ev(DCD, MAC_A);
    wt(dcd_fwd_ff, 3, 1'b0);
    ev(NOMDD, '0);
    wt(legacy_init_ff, 4, 1'b1);
    ev(USF, '0);
    wt(note_vld_ff, 4, 1'b1);
    cmp(note_ff.kind, NOTE_ONE_WAY);
    ev(CANF, 48'h5);
    wt(note_vld_ff, 4, 1'b1);
    cmp(note_ff.kind, NOTE_CANNOT_FWD);
    cmp(note_ff.network_access_flag, 1'b1);
    cmp(note_ff.max_attached_hosts, 8'h05);
    ev(CHG, 48'h2);
    wt(note_vld_ff, 4, 1'b1);
    cmp(note_ff.kind, NOTE_CHAN_CHANGE);
    cmp(note_ff.init_type, 8'h02);
  endtask

  initial begin
    do_reset();
    t_idle();
    t_timeout();
    t_accept();
    t_hunt();
    t_legacy();
    give_verdict();
  end
endmodule // gw_acq_tb
`default_nettype wire
